/* File: pkg/mlf_consts.vh */
/*
  Constants for the multimode line delay FIFO: memory geometry, register map,
  mode select codes and pin vector layout.
  Assumes inclusion by bare name from core/ files; holds definitions only.
*/
//
// Contract
// RULE_01: mode 3 chains FIFO A into B as 8-bit two-line delay; C independent.
// RULE_02: write enable A low: each write clock A rise stores word, advances write counter.
// RULE_03: write enable A high: write clock A edges ignored, counter holds.
// RULE_04: write pointer reset A low at an edge clears FIFO A write counter.
// RULE_05: mode 3, read enable A low: read clock A drives buses A, B; counters advance.
// RULE_06: cascaded modes: word read from A is written into B on same edge.
// RULE_07: mode 3, read enable A high: A/B reads and B writes halt; buses A, B float.
// RULE_08: cascaded modes: read pointer reset A clears A read and both B counters.
// RULE_09: mode 3: FIFO C behaves as independent mode 1 FIFO on system C pins.
// RULE_10: mode 3: outside logic holds system B controls and input bus B fixed.
// RULE_11: mode 4: two independent 12-bit FIFOs, A on system A, B on system B.
// RULE_12: modes 4, 5: FIFO A word is input A bits 7..0 over input B bits 3..0.
// RULE_13: mode 4: FIFO A out on bus A and bus B low nibble; floats when disabled.
// RULE_14: mode 4: FIFO B word from input C and input B high nibble, same on outputs.
// RULE_15: mode 4: outside logic ties system C controls to constant levels.
// RULE_16: mode 5: read clock A outputs A on A/B low, B on C/B high.
// RULE_17: mode 5, read enable A high: both FIFOs halt, all data outputs float.
// RULE_18: mode 5: outside logic holds system B, C controls, input B high, input C fixed.
// RULE_19: cascaded modes: second FIFO controlled only by first line read pins.
// RULE_20: mode select 000..100 picks modes 1..5; any other pattern picks mode 1.
// RULE_21: independent FIFO: read enable high halts read counter and floats its bus.
// RULE_22: each counter spans 262144 words, wraps to zero; write and read sides unrelated.

`ifndef MLF_CONSTS_VH
`define MLF_CONSTS_VH

// ==================================================
// memory geometry
`define MLF_ADDR_W 18
`define MLF_WORD_W 12
`define MLF_BYTE_W 8
`define MLF_NIB_W 4
`define MLF_NIB_ZERO 4'h0

// ==================================================
// register map (byte addresses)
`define MLF_REG_CTRL 4'h0
`define MLF_REG_STAT 4'h4
`define MLF_REG_WPTR 4'h8
`define MLF_REG_RPTR 4'hc
`define MLF_CTRL_RST 3'h0
`define MLF_MSEL_W 3

// ==================================================
// mode select codes
`define MLF_MSEL_M1 3'h0
`define MLF_MSEL_M2 3'h1
`define MLF_MSEL_M3 3'h2
`define MLF_MSEL_M4 3'h3
`define MLF_MSEL_M5 3'h4

// ==================================================
// per system pin vector layout
`define MLF_SYS_N 3
`define MLF_CPIN_N 6
`define MLF_P_WCLK 0
`define MLF_P_WEN 1
`define MLF_P_WRST 2
`define MLF_P_RCLK 3
`define MLF_P_REN 4
`define MLF_P_RRST 5

`endif

/* File: core/mlf_fifo_mem.v */
/*
  One FIFO bank: word array with independent write and read address counters.
  Assumes edge qualified strobes from the pin front end on the same clock.
*/
`timescale 1ns/1ps
`include "mlf_consts.vh"

module mlf_fifo_mem #(
  parameter WIDTH = `MLF_WORD_W,
  parameter ADDR_W = `MLF_ADDR_W
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire wr_i,
  input wire wr_rst_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire rd_i,
  input wire rd_rst_i,
  output wire [WIDTH-1:0] rd_word_o,
  output wire [ADDR_W-1:0] wr_ptr_o,
  output wire [ADDR_W-1:0] rd_ptr_o
);

  localparam [ADDR_W-1:0] PTR_ZERO = {ADDR_W{1'b0}};
  localparam [ADDR_W-1:0] PTR_ONE = {{(ADDR_W-1){1'b0}}, 1'b1};

  reg [WIDTH-1:0] mem_r [0:(1<<ADDR_W)-1];
  reg [ADDR_W-1:0] wr_ptr_r;
  reg [ADDR_W-1:0] rd_ptr_r;

  // ==================================================
  // storage; pointer reset wins over a store on the same edge
  always @(posedge clock_i) begin
    if (wr_i && !wr_rst_i) begin
      mem_r[wr_ptr_r] <= wr_data_i; // RULE_02
    end
  end

  // ==================================================
  // counters wrap naturally at the top of the array
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= PTR_ZERO;
      rd_ptr_r <= PTR_ZERO;
    end else begin
      if (wr_rst_i) begin
        wr_ptr_r <= PTR_ZERO; // RULE_04
      end else if (wr_i) begin
        wr_ptr_r <= wr_ptr_r + PTR_ONE; // RULE_22
      end
      if (rd_rst_i) begin
        rd_ptr_r <= PTR_ZERO;
      end else if (rd_i) begin
        rd_ptr_r <= rd_ptr_r + PTR_ONE; // RULE_22
      end
    end
  end

  // word at the read counter, seen before the counter moves
  assign rd_word_o = mem_r[rd_ptr_r];
  assign wr_ptr_o = wr_ptr_r;
  assign rd_ptr_o = rd_ptr_r;

endmodule // mlf_fifo_mem

/* File: core/mlf_line_delay.v */
/*
  Multimode line delay FIFO top: pin front end, mode routing of three FIFO
  banks, three-state output buses and an Avalon-MM register slave.
  Assumes all pins are asynchronous to clock_i and each pin level, including
  the pin clocks, stays for at least two clock_i cycles.
*/
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "mlf_consts.vh"

module mlf_line_delay #(
  parameter ADDR_W = `MLF_ADDR_W
) (
  input wire clock_i,
  input wire rst_n_i,
  // avalon-mm slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // system pins, index 0 = A, 1 = B, 2 = C
  input wire write_clock_a_i,
  input wire write_clock_b_i,
  input wire write_clock_c_i,
  input wire wr_en_a_n_i,
  input wire wr_en_b_n_i,
  input wire wr_en_c_n_i,
  input wire write_ptr_reset_a_n_i,
  input wire write_ptr_reset_b_n_i,
  input wire write_ptr_reset_c_n_i,
  input wire rd_clock_a_i,
  input wire rd_clock_b_i,
  input wire rd_clock_c_i,
  input wire rd_en_a_n_i,
  input wire rd_en_b_n_i,
  input wire rd_en_c_n_i,
  input wire rd_ptr_reset_a_n_i,
  input wire rd_ptr_reset_b_n_i,
  input wire rd_ptr_reset_c_n_i,
  input wire [7:0] input_bus_a_i,
  input wire [7:0] input_bus_b_i,
  input wire [7:0] input_bus_c_i,
  output wire [7:0] output_bus_a_o,
  output wire [7:0] output_bus_b_o,
  output wire [7:0] output_bus_c_o,
  output wire [7:0] output_bus_a_oe_o,
  output wire [7:0] output_bus_b_oe_o,
  output wire [7:0] output_bus_c_oe_o
);

  // one-hot mode codes
  localparam [4:0] MODE_1 = 5'h01;
  localparam [4:0] MODE_2 = 5'h02;
  localparam [4:0] MODE_3 = 5'h04;
  localparam [4:0] MODE_4 = 5'h08;
  localparam [4:0] MODE_5 = 5'h10;
  localparam CPIN_W = `MLF_SYS_N * `MLF_CPIN_N;
  localparam SYNC_W = CPIN_W + `MLF_SYS_N * `MLF_BYTE_W;

  // mode select decode, unknown patterns fall back to mode 1
  function [4:0] mlf_decode;
    input [`MLF_MSEL_W-1:0] sel;
    begin
      case (sel)
        `MLF_MSEL_M2: mlf_decode = MODE_2;
        `MLF_MSEL_M3: mlf_decode = MODE_3;
        `MLF_MSEL_M4: mlf_decode = MODE_4;
        `MLF_MSEL_M5: mlf_decode = MODE_5;
        default: mlf_decode = MODE_1; // RULE_20
      endcase
    end
  endfunction

  // ==================================================
  // pin synchroniser
  wire [SYNC_W-1:0] pin_raw;
  reg [SYNC_W-1:0] sync1_r;
  reg [SYNC_W-1:0] sync2_r;
  reg [CPIN_W-1:0] prev_r;

  assign pin_raw = {input_bus_c_i, input_bus_b_i, input_bus_a_i,
                    rd_ptr_reset_c_n_i, rd_en_c_n_i, rd_clock_c_i,
                    write_ptr_reset_c_n_i, wr_en_c_n_i, write_clock_c_i,
                    rd_ptr_reset_b_n_i, rd_en_b_n_i, rd_clock_b_i,
                    write_ptr_reset_b_n_i, wr_en_b_n_i, write_clock_b_i,
                    rd_ptr_reset_a_n_i, rd_en_a_n_i, rd_clock_a_i,
                    write_ptr_reset_a_n_i, wr_en_a_n_i, write_clock_a_i};

  // two stages before use; a third copy of stage two finds clock rises
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= {SYNC_W{1'b0}};
      sync2_r <= {SYNC_W{1'b0}};
      prev_r <= {CPIN_W{1'b0}};
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      prev_r <= sync2_r[CPIN_W-1:0];
    end
  end

  wire [7:0] din_a = sync2_r[CPIN_W+7:CPIN_W];
  wire [7:0] din_b = sync2_r[CPIN_W+15:CPIN_W+8];
  wire [7:0] din_c = sync2_r[CPIN_W+23:CPIN_W+16];

  // ==================================================
  // per system edge strobes
  wire [`MLF_SYS_N-1:0] wr_s;
  wire [`MLF_SYS_N-1:0] wrst_s;
  wire [`MLF_SYS_N-1:0] rev_s;
  wire [`MLF_SYS_N-1:0] ren_s;
  wire [`MLF_SYS_N-1:0] rd_s;
  wire [`MLF_SYS_N-1:0] rrst_s;

  genvar s;
  generate
    for (s = 0; s < `MLF_SYS_N; s = s + 1) begin : g_sys
      wire [`MLF_CPIN_N-1:0] cur = sync2_r[s*`MLF_CPIN_N +: `MLF_CPIN_N];
      wire [`MLF_CPIN_N-1:0] old = prev_r[s*`MLF_CPIN_N +: `MLF_CPIN_N];
      wire wev = cur[`MLF_P_WCLK] & ~old[`MLF_P_WCLK];
      // enable high leaves the edge without a store; a pointer reset still acts
      assign wr_s[s] = wev & ~cur[`MLF_P_WEN]; // RULE_02 RULE_03
      assign wrst_s[s] = wev & ~cur[`MLF_P_WRST]; // RULE_04
      assign rev_s[s] = cur[`MLF_P_RCLK] & ~old[`MLF_P_RCLK];
      assign ren_s[s] = ~cur[`MLF_P_REN];
      assign rd_s[s] = rev_s[s] & ren_s[s]; // RULE_21
      assign rrst_s[s] = rev_s[s] & ~cur[`MLF_P_RRST];
    end
  endgenerate

  // ==================================================
  // mode routing of the three banks
  reg [`MLF_MSEL_W-1:0] msel_r;
  wire [4:0] mode_oh = mlf_decode(msel_r);
  wire cas_ab = mode_oh[1] | mode_oh[2] | mode_oh[4]; // RULE_01
  wire cas_bc = mode_oh[1];
  wire wide = mode_oh[3] | mode_oh[4];

  wire [`MLF_WORD_W-1:0] word_a;
  wire [`MLF_WORD_W-1:0] word_b;
  wire [`MLF_BYTE_W-1:0] word_c;
  wire [ADDR_W-1:0] wptr_a;
  wire [ADDR_W-1:0] rptr_a;

  // narrow modes keep the byte in the upper eight bits
  wire [`MLF_WORD_W-1:0] wdata_a = wide ? {din_a, din_b[3:0]} : {din_a, `MLF_NIB_ZERO}; // RULE_12
  // second line fed only by first line read pins in cascade
  wire wr_b = cas_ab ? rd_s[0] : wr_s[1]; // RULE_06 RULE_19
  wire wrst_b = cas_ab ? rrst_s[0] : wrst_s[1]; // RULE_08
  wire rd_b = cas_ab ? rd_s[0] : rd_s[1]; // RULE_05 RULE_11
  wire rrst_b = cas_ab ? rrst_s[0] : rrst_s[1]; // RULE_08
  wire [`MLF_WORD_W-1:0] wdata_b = cas_ab ? word_a :
                                  (mode_oh[3] ? {din_c, din_b[7:4]} : {din_b, `MLF_NIB_ZERO}); // RULE_14
  // bank C is independent except in the three-line chain
  wire wr_c = cas_bc ? rd_s[0] : wr_s[2]; // RULE_09
  wire wrst_c = cas_bc ? rrst_s[0] : wrst_s[2];
  wire rd_c = cas_bc ? rd_s[0] : rd_s[2];
  wire rrst_c = cas_bc ? rrst_s[0] : rrst_s[2];
  wire [`MLF_BYTE_W-1:0] wdata_c = cas_bc ? word_b[11:4] : din_c;

  mlf_fifo_mem #(.WIDTH(`MLF_WORD_W), .ADDR_W(ADDR_W)) u_fifo_a (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_s[0]),
    .wr_rst_i(wrst_s[0]),
    .wr_data_i(wdata_a),
    .rd_i(rd_s[0]),
    .rd_rst_i(rrst_s[0]),
    .rd_word_o(word_a),
    .wr_ptr_o(wptr_a),
    .rd_ptr_o(rptr_a)
  );

  mlf_fifo_mem #(.WIDTH(`MLF_WORD_W), .ADDR_W(ADDR_W)) u_fifo_b (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_b),
    .wr_rst_i(wrst_b),
    .wr_data_i(wdata_b),
    .rd_i(rd_b),
    .rd_rst_i(rrst_b),
    .rd_word_o(word_b),
    .wr_ptr_o(),
    .rd_ptr_o()
  );

  mlf_fifo_mem #(.WIDTH(`MLF_BYTE_W), .ADDR_W(ADDR_W)) u_fifo_c (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_c),
    .wr_rst_i(wrst_c),
    .wr_data_i(wdata_c),
    .rd_i(rd_c),
    .rd_rst_i(rrst_c),
    .rd_word_o(word_c),
    .wr_ptr_o(),
    .rd_ptr_o()
  );

  // ==================================================
  // output buses; enables follow the read enable seen at each read edge
  reg [7:0] q_a_r;
  reg [7:0] q_b_r;
  reg [7:0] q_c_r;
  reg oe_a_r;
  reg oe_bl_r;
  reg oe_bh_r;
  reg oe_c_r;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_a_r <= 8'h00;
      q_b_r <= 8'h00;
      q_c_r <= 8'h00;
      oe_a_r <= 1'b0;
      oe_bl_r <= 1'b0;
      oe_bh_r <= 1'b0;
      oe_c_r <= 1'b0;
    end else begin
      // bus A carries the upper byte of bank A in every mode
      if (rev_s[0]) begin
        oe_a_r <= ren_s[0]; // RULE_07 RULE_13 RULE_17
        if (ren_s[0]) begin
          q_a_r <= word_a[11:4]; // RULE_05
        end
      end
      case (mode_oh)
        MODE_4: begin
          if (rev_s[0]) begin
            oe_bl_r <= ren_s[0]; // RULE_13
            if (ren_s[0]) begin
              q_b_r[3:0] <= word_a[3:0]; // RULE_13
            end
          end
          if (rev_s[1]) begin
            oe_bh_r <= ren_s[1];
            oe_c_r <= ren_s[1];
            if (ren_s[1]) begin
              q_b_r[7:4] <= word_b[3:0]; // RULE_14
              q_c_r <= word_b[11:4]; // RULE_14
            end
          end
        end
        MODE_5: begin
          if (rev_s[0]) begin
            oe_bl_r <= ren_s[0]; // RULE_17
            oe_bh_r <= ren_s[0];
            oe_c_r <= ren_s[0];
            if (ren_s[0]) begin
              q_b_r <= {word_b[3:0], word_a[3:0]}; // RULE_16
              q_c_r <= word_b[11:4]; // RULE_16
            end
          end
        end
        MODE_3: begin
          if (rev_s[0]) begin
            oe_bl_r <= ren_s[0]; // RULE_07
            oe_bh_r <= ren_s[0];
            if (ren_s[0]) begin
              q_b_r <= word_b[11:4]; // RULE_05
            end
          end
          if (rev_s[2]) begin
            oe_c_r <= ren_s[2]; // RULE_09
            if (ren_s[2]) begin
              q_c_r <= word_c;
            end
          end
        end
        MODE_2: begin
          if (rev_s[0]) begin
            oe_bl_r <= ren_s[0];
            oe_bh_r <= ren_s[0];
            oe_c_r <= ren_s[0];
            if (ren_s[0]) begin
              q_b_r <= word_b[11:4];
              q_c_r <= word_c;
            end
          end
        end
        default: begin
          // mode 1: each bus follows its own system
          if (rev_s[1]) begin
            oe_bl_r <= ren_s[1]; // RULE_21
            oe_bh_r <= ren_s[1];
            if (ren_s[1]) begin
              q_b_r <= word_b[11:4];
            end
          end
          if (rev_s[2]) begin
            oe_c_r <= ren_s[2]; // RULE_21
            if (ren_s[2]) begin
              q_c_r <= word_c;
            end
          end
        end
      endcase
    end
  end

  assign output_bus_a_o = q_a_r;
  assign output_bus_b_o = q_b_r;
  assign output_bus_c_o = q_c_r;
  assign output_bus_a_oe_o = {8{oe_a_r}};
  assign output_bus_b_oe_o = {{4{oe_bh_r}}, {4{oe_bl_r}}};
  assign output_bus_c_oe_o = {8{oe_c_r}};

  // ==================================================
  // avalon-mm slave: one wait state, read data captured in the first cycle
  reg ack_r;
  reg [31:0] rdata_r;
  reg [31:0] rdata_nxt;
  wire req = avs_read_i | avs_write_i;

  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address_i)
      `MLF_REG_CTRL: rdata_nxt[`MLF_MSEL_W-1:0] = msel_r;
      `MLF_REG_STAT: rdata_nxt[4:0] = mode_oh;
      `MLF_REG_WPTR: rdata_nxt[ADDR_W-1:0] = wptr_a;
      `MLF_REG_RPTR: rdata_nxt[ADDR_W-1:0] = rptr_a;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // a mode change takes effect at once; retune only while links are idle
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      msel_r <= `MLF_CTRL_RST;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_read_i && !ack_r) begin
        rdata_r <= rdata_nxt;
      end
      if (avs_write_i && ack_r && avs_address_i == `MLF_REG_CTRL && avs_byteenable_i[0]) begin
        msel_r <= avs_writedata_i[`MLF_MSEL_W-1:0]; // RULE_20
      end
    end
  end

  assign avs_waitrequest_o = req & ~ack_r;
  assign avs_readdata_o = rdata_r;

endmodule // mlf_line_delay

/* File: bench/mlf_line_delay_sva.sv */
/* port checker for the line delay fifo top.
   assumes pins held stable around each pin clock edge; bound below. */
`timescale 1ns/1ps
module mlf_line_delay_sva (
  input wire clock_i,
  input wire rst_n_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire rd_clock_a_i,
  input wire rd_clock_b_i,
  input wire rd_clock_c_i,
  input wire rd_en_a_n_i,
  input wire rd_en_b_n_i,
  input wire rd_en_c_n_i,
  input wire [7:0] output_bus_a_oe_o,
  input wire [7:0] output_bus_b_oe_o,
  input wire [7:0] output_bus_c_oe_o
);
  // ====================================
  // mode shadow and properties
  reg [2:0] mode_r;
  wire [4:0] hot_w = (mode_r > 3'h4) ? 5'h01 : (5'h01 << mode_r);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // shadow follows accepted control writes only, so bus refusals are honoured
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) mode_r <= 3'h0;
    else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0 && avs_byteenable_i[0])
      mode_r <= avs_writedata_i[2:0];
  end
  property p_a_on;
    $rose(rd_clock_a_i) && !rd_en_a_n_i |-> ##3 output_bus_a_oe_o == 8'hff;
  endproperty
  a_a_on: assert property (p_a_on) else $error("bus a idle after enabled read");
  property p_a_off;
    $rose(rd_clock_a_i) && rd_en_a_n_i |-> ##3 output_bus_a_oe_o == 8'h00;
  endproperty
  a_a_off: assert property (p_a_off) else $error("bus a driven after disabled read");
  property p_m3_b;
    mode_r == 3'h2 && $rose(rd_clock_a_i) && !rd_en_a_n_i |-> ##3 output_bus_b_oe_o == 8'hff;
  endproperty
  a_m3_b: assert property (p_m3_b) else $error("second line bus idle");
  property p_m5_on;
    mode_r == 3'h4 && $rose(rd_clock_a_i) && !rd_en_a_n_i |-> ##3 {output_bus_c_oe_o, output_bus_b_oe_o} == 16'hffff;
  endproperty
  a_m5_on: assert property (p_m5_on) else $error("wide cascade buses idle");
  property p_m5_off;
    mode_r == 3'h4 && $rose(rd_clock_a_i) && rd_en_a_n_i
      |-> ##3 {output_bus_c_oe_o, output_bus_b_oe_o, output_bus_a_oe_o} == 24'h0;
  endproperty
  a_m5_off: assert property (p_m5_off) else $error("wide cascade not floated");
  property p_m4_b;
    mode_r == 3'h3 && $rose(rd_clock_b_i) && !rd_en_b_n_i
      |-> ##3 output_bus_c_oe_o == 8'hff && output_bus_b_oe_o[7:4] == 4'hf;
  endproperty
  a_m4_b: assert property (p_m4_b) else $error("wide fifo b buses idle");
  property p_m3_c;
    mode_r == 3'h2 && $rose(rd_clock_c_i) && rd_en_c_n_i |-> ##3 output_bus_c_oe_o == 8'h00;
  endproperty
  a_m3_c: assert property (p_m3_c) else $error("fifo c bus not floated");
  property p_req;
    $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o;
  endproperty
  a_req: assert property (p_req) else $error("request not held off");
  property p_ack;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_stat;
    avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h4 |-> avs_readdata_o == {27'h0, hot_w};
  endproperty
  a_stat: assert property (p_stat) else $error("status mode wrong");
endmodule // mlf_line_delay_sva

bind mlf_line_delay mlf_line_delay_sva u_sva (.clock_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .rd_clock_a_i, .rd_clock_b_i,
  .rd_clock_c_i, .rd_en_a_n_i, .rd_en_b_n_i, .rd_en_c_n_i, .output_bus_a_oe_o, .output_bus_b_oe_o,
  .output_bus_c_oe_o);

/* File: bench/mlf_pins_model.sv */
/* far side logic driving the three pin systems.
   assumes pins sampled by clock_i; one pin operation at a time. */
`timescale 1ns/1ps
module mlf_pins_model (
  input wire clock_i,
  output reg [17:0] ctl_o,
  output reg [23:0] data_o
);
  // ====================================
  // idle: clocks low, enables and resets off; unused systems stay fixed
  initial begin
    ctl_o = {3{6'h36}};
    data_o = 24'h0;
  end
  // one pin clock of system s; levels held 3 cycles each so the sync sees them
  task cyc(input integer s, input integer wr, input en_n, input prst_n, input [23:0] d);
    integer b;
    begin
      b = s * 6 + (wr ? 0 : 3);
      @(posedge clock_i);
      data_o <= d;
      ctl_o[b+1] <= en_n;
      ctl_o[b+2] <= prst_n;
      repeat (2) @(posedge clock_i);
      ctl_o[b] <= 1'b1;
      repeat (3) @(posedge clock_i);
      ctl_o[b] <= 1'b0;
      repeat (3) @(posedge clock_i);
      ctl_o[b+1] <= 1'b1;
      ctl_o[b+2] <= 1'b1;
    end
  endtask
endmodule // mlf_pins_model

/* File: bench/mlf_line_delay_tb_top.sv */
/* self checking bench for the line delay fifo top.
   assumes pin model drives all pins; pointers shortened to 64 words. */
`timescale 1ns/1ps
module mlf_line_delay_tb_top;
  // ====================================
  // signals
  reg clock_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'h0;
  wire [31:0] rdata;
  wire wait_w;
  wire [17:0] ctl;
  wire [23:0] din;
  wire [7:0] qa, qb, qc, ea, eb, ec;
  integer errors = 0;
  integer comparisons = 0;
  integer i;
  reg [31:0] q;
  reg [76:0] rows [0:8];
  reg [76:0] r;
  always #25 clock_i = ~clock_i;
  mlf_pins_model u_pins (.clock_i(clock_i), .ctl_o(ctl), .data_o(din));
  mlf_line_delay #(.ADDR_W(6)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(avs_byteenable), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_w),
    .write_clock_a_i(ctl[0]), .wr_en_a_n_i(ctl[1]), .write_ptr_reset_a_n_i(ctl[2]), .rd_clock_a_i(ctl[3]),
    .rd_en_a_n_i(ctl[4]), .rd_ptr_reset_a_n_i(ctl[5]), .write_clock_b_i(ctl[6]), .wr_en_b_n_i(ctl[7]),
    .write_ptr_reset_b_n_i(ctl[8]), .rd_clock_b_i(ctl[9]), .rd_en_b_n_i(ctl[10]), .rd_ptr_reset_b_n_i(ctl[11]),
    .write_clock_c_i(ctl[12]), .wr_en_c_n_i(ctl[13]), .write_ptr_reset_c_n_i(ctl[14]), .rd_clock_c_i(ctl[15]),
    .rd_en_c_n_i(ctl[16]), .rd_ptr_reset_c_n_i(ctl[17]), .input_bus_a_i(din[7:0]), .input_bus_b_i(din[15:8]),
    .input_bus_c_i(din[23:16]), .output_bus_a_o(qa), .output_bus_b_o(qb), .output_bus_c_o(qc),
    .output_bus_a_oe_o(ea), .output_bus_b_oe_o(eb), .output_bus_c_oe_o(ec));
  // ====================================
  // tasks
  task end_sim;
    begin
      if (errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [47:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one avalon transfer; held until waitrequest is seen low
  task bus(input wr, input [3:0] a, input [31:0] d, input [3:0] be, output [31:0] rq);
    integer n;
    begin
      @(posedge clock_i);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      @(posedge clock_i);
      while (wait_w !== 1'b0 && n < 20) begin
        n = n + 1;
        @(posedge clock_i);
      end
      if (n == 20) begin
        errors = errors + 1;
        end_sim;
      end
      rq = rdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0, 4'hf, q);
      chk("reg", q, e);
    end
  endtask
  task wreg(input [3:0] a, input [31:0] d);
    bus(1'b1, a, d, 4'hf, q);
  endtask
  // two line delay: second pass must show the first pass on the lower line
  task casc(input [2:0] m);
    integer k;
    reg [23:0] mk;
    reg [23:0] e;
    begin
      mk = (m == 3'h4) ? 24'hffffff : 24'h00ffff;
      wreg(4'h0, {29'h0, m});
      u_pins.cyc(0, 1, 1'b1, 1'b0, 24'h0);
      for (k = 0; k < 4; k = k + 1)
        u_pins.cyc(0, 1, 1'b0, 1'b1, {8'h00, (m == 3'h4) ? k[7:0] : 8'h00, 8'h10 + k[7:0]});
      rd(4'h8, 32'h4);
      u_pins.cyc(0, 1, 1'b1, 1'b1, 24'h0);
      rd(4'h8, 32'h4);
      u_pins.cyc(0, 0, 1'b1, 1'b0, 24'h0);
      for (k = 0; k < 4; k = k + 1) begin
        u_pins.cyc(0, 0, 1'b0, 1'b1, 24'h0);
        chk("qa", qa, 8'h10 + k[7:0]);
      end
      u_pins.cyc(0, 0, 1'b1, 1'b1, 24'h0);
      rd(4'hc, 32'h4);
      chk("oe_off", {ec, eb, ea} & mk, 24'h0);
      u_pins.cyc(0, 1, 1'b1, 1'b0, 24'h0);
      rd(4'h8, 32'h0);
      for (k = 0; k < 4; k = k + 1)
        u_pins.cyc(0, 1, 1'b0, 1'b1, {8'h00, (m == 3'h4) ? 8'h04 + k[7:0] : 8'h00, 8'h20 + k[7:0]});
      u_pins.cyc(0, 0, 1'b1, 1'b0, 24'h0);
      rd(4'hc, 32'h0);
      for (k = 0; k < 4; k = k + 1) begin
        u_pins.cyc(0, 0, 1'b0, 1'b1, 24'h0);
        e = (m == 3'h4) ? {8'h10 + k[7:0], k[3:0], 4'h4 + k[3:0], 8'h20 + k[7:0]} :
            {8'h00, 8'h10 + k[7:0], 8'h20 + k[7:0]};
        chk("line", {qc, qb, qa} & mk, e & mk);
      end
    end
  endtask
  // ====================================
  // main sequence
  initial begin
    // rows: mode, system, input buses, checked bits, expected outputs
    rows[0] = {3'h0, 2'h0, 24'h00005a, 24'h0000ff, 24'h00005a};
    rows[1] = {3'h0, 2'h1, 24'h003c00, 24'h00ff00, 24'h003c00};
    rows[2] = {3'h0, 2'h2, 24'hc30000, 24'hff0000, 24'hc30000};
    rows[3] = {3'h2, 2'h2, 24'h960000, 24'hff0000, 24'h960000};
    rows[4] = {3'h3, 2'h0, 24'h00e7a5, 24'h000fff, 24'h0007a5};
    rows[5] = {3'h3, 2'h1, 24'h69b400, 24'hfff000, 24'h69b000};
    rows[6] = {3'h4, 2'h0, 24'h002d1e, 24'h000fff, 24'h000d1e};
    rows[7] = {3'h2, 2'h0, 24'h000077, 24'h0000ff, 24'h000077};
    // three line chain: first line still reaches bus a
    rows[8] = {3'h1, 2'h0, 24'h000044, 24'h0000ff, 24'h000044};
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd(4'h4, 32'h1);
    chk("oe_rst", {ec, eb, ea}, 24'h0);
    for (i = 0; i < 8; i = i + 1) begin
      wreg(4'h0, i);
      rd(4'h4, (i > 4) ? 32'h1 : (32'h1 << i));
    end
    bus(1'b1, 4'h0, 32'h3, 4'he, q);
    rd(4'h4, 32'h1);
    rd(4'h0, 32'h7);
    for (i = 0; i < 9; i = i + 1) begin
      r = rows[i];
      wreg(4'h0, {29'h0, r[76:74]});
      u_pins.cyc(r[73:72], 1, 1'b1, 1'b0, r[71:48]);
      u_pins.cyc(r[73:72], 1, 1'b0, 1'b1, r[71:48]);
      u_pins.cyc(r[73:72], 0, 1'b1, 1'b0, r[71:48]);
      u_pins.cyc(r[73:72], 0, 1'b0, 1'b1, r[71:48]);
      chk("q", {qc, qb, qa} & r[47:24], r[23:0]);
      chk("oe", {ec, eb, ea} & r[47:24], r[47:24]);
    end
    casc(3'h2);
    casc(3'h4);
    u_pins.cyc(0, 1, 1'b1, 1'b0, 24'h0);
    for (i = 0; i < 64; i = i + 1)
      u_pins.cyc(0, 1, 1'b0, 1'b1, 24'h0);
    rd(4'h8, 32'h0);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(4'h4, 32'h1);
    chk("oe_rst", {ec, eb, ea}, 24'h0);
    end_sim;
  end
endmodule // mlf_line_delay_tb_top
